// file: include/cfp_pkg.sv
// Package for the CAN acceptance filter configuration block.
// Holds register offsets, reset values and the identifier key layouts.
// Assumes a 12-bit byte address window from the peripheral bus.
package cfp_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int unsigned CFP_NUM_BANKS = 14;
  localparam int unsigned CFP_ADR_W = 12;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [11:0] CFP_MASTER_OFS = 12'h200;
  localparam logic [11:0] CFP_MODE_OFS = 12'h204;
  localparam logic [11:0] CFP_SCALE_OFS = 12'h20C;
  localparam logic [11:0] CFP_ROUTE_OFS = 12'h214;
  localparam logic [11:0] CFP_ACT_OFS = 12'h21C;
  localparam logic [11:0] CFP_BANK_FIRST_OFS = 12'h240;
  localparam logic [11:0] CFP_BANK_LAST_OFS = 12'h2AC;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [31:0] CFP_MASTER_RESET = 32'h2A1C_0E01;
  localparam logic [31:0] CFP_ZERO_RESET = 32'h0000_0000;
  localparam int unsigned CFP_INIT_BIT = 0;

  // Key for one 32-bit filter: std id, ext id, ide, rtr, one zero bit
  function automatic logic [31:0] cfp_key32(input logic [10:0] std_id, input logic [17:0] ext_id,
                                            input logic ide, input logic rtr);
    cfp_key32 = {std_id, ext_id, ide, rtr, 1'b0};
  endfunction : cfp_key32

  // Key for one 16-bit filter: std id, rtr, ide, top three ext id bits
  function automatic logic [15:0] cfp_key16(input logic [10:0] std_id, input logic [17:0] ext_id,
                                            input logic ide, input logic rtr);
    cfp_key16 = {std_id, rtr, ide, ext_id[17:15]};
  endfunction : cfp_key16

endpackage : cfp_pkg

// file: verilog/cfp_bank_match.sv
// One filter bank's identifier comparison, purely combinational.
// Assumes the caller gates the result with the bank's activation bit.
`timescale 1ns/1ps
module cfp_bank_match import cfp_pkg::*; (
  // Bank configuration
  input wire logic [31:0] word1_i,
  input wire logic [31:0] word2_i,
  input wire logic list_mode_i,
  input wire logic scale_32_i,
  // Incoming identifier
  input wire logic [10:0] std_id_i,
  input wire logic [17:0] ext_id_i,
  input wire logic ide_i,
  input wire logic rtr_i,
  // Result
  output logic hit_o
);

  logic [31:0] key32;
  logic [15:0] key16;
  logic m32_mask;
  logic m32_list;
  logic m16_mask;
  logic m16_list;

  always_comb begin
    // Same key feeds mask and list comparisons
    key32 = cfp_key32(std_id_i, ext_id_i, ide_i, rtr_i);
    key16 = cfp_key16(std_id_i, ext_id_i, ide_i, rtr_i);
    // Mask bit 0 ignores the bit, 1 demands equality with the identifier word
    m32_mask = ((key32 ^ word1_i) & word2_i) == 32'h0000_0000;
    m32_list = (key32 == word1_i) || (key32 == word2_i);
    m16_mask = (((key16 ^ word1_i[15:0]) & word1_i[31:16]) == 16'h0000) ||
               (((key16 ^ word2_i[15:0]) & word2_i[31:16]) == 16'h0000);
    m16_list = (key16 == word1_i[15:0]) || (key16 == word1_i[31:16]) ||
               (key16 == word2_i[15:0]) || (key16 == word2_i[31:16]);
    if (scale_32_i) begin
      hit_o = list_mode_i ? m32_list : m32_mask;
    end else begin
      hit_o = list_mode_i ? m16_list : m16_mask;
    end
  end

endmodule : cfp_bank_match

// file: verilog/cfp_first_hit.sv
// Picks the lowest numbered bank out of a vector of hits.
// Assumes IW is wide enough to number all N banks.
`timescale 1ns/1ps
module cfp_first_hit #(
  parameter int unsigned N = 14,
  parameter int unsigned IW = 4
) (
  // Hits per bank
  input wire logic [N-1:0] hits_i,
  // Winner
  output logic any_o,
  output logic [IW-1:0] index_o
);

  always_comb begin
    any_o = |hits_i;
    index_o = '0;
    // Walking down leaves the lowest hit as the last one written
    for (int i = N - 1; i >= 0; i--) begin
      if (hits_i[i]) begin
        index_o = IW'(i);
      end
    end
  end

endmodule : cfp_first_hit

// file: verilog/cfp_filter_config.sv
// CAN acceptance filter configuration and matching, with a Wishbone slave.
// Assumes a classic Wishbone master on clk_i and a receive path on the same
// clock that presents one identifier per rx_frame_valid_i pulse.
`timescale 1ns/1ps
module cfp_filter_config import cfp_pkg::*; #(
  parameter int unsigned NUM_BANKS = CFP_NUM_BANKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [CFP_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive path identifier
  input wire logic rx_frame_valid_i,
  input wire logic [10:0] rx_std_id_i,
  input wire logic [17:0] rx_ext_id_i,
  input wire logic rx_ide_i,
  input wire logic rx_rtr_i,
  // Filtering verdict
  output logic acc_valid_o,
  output logic acc_fifo1_o,
  output logic [$clog2(NUM_BANKS)-1:0] acc_bank_o,
  output logic discard_o
);

  localparam int unsigned IW = $clog2(NUM_BANKS);
  localparam int unsigned WW = $clog2(2 * NUM_BANKS);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic init_mode;
    logic [NUM_BANKS-1:0] list_mode;
    logic [NUM_BANKS-1:0] scale_32;
    logic [NUM_BANKS-1:0] fifo_sel;
    logic [NUM_BANKS-1:0] active;
    logic [2*NUM_BANKS-1:0][31:0] bank_words;
    logic ack;
    logic [31:0] rdata;
    logic acc_valid;
    logic acc_fifo1;
    logic [IW-1:0] acc_bank;
    logic discard;
  } cfp_state_type;

  cfp_state_type state_reg;
  cfp_state_type state_next;

  logic [NUM_BANKS-1:0] bank_hit;
  logic [NUM_BANKS-1:0] live_hit;
  logic any_hit;
  logic [IW-1:0] hit_index;

  // ************************************************************
  // Byte lane merge for writes
  // ************************************************************
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_val, input logic [31:0] new_val,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    merge_lanes = res;
  endfunction : merge_lanes

  // ************************************************************
  // Bank comparators
  // ************************************************************
  for (genvar g = 0; g < NUM_BANKS; g++) begin : gen_bank
    cfp_bank_match u_match (
      .word1_i(state_reg.bank_words[2*g]),
      .word2_i(state_reg.bank_words[2*g+1]),
      .list_mode_i(state_reg.list_mode[g]),
      .scale_32_i(state_reg.scale_32[g]),
      .std_id_i(rx_std_id_i),
      .ext_id_i(rx_ext_id_i),
      .ide_i(rx_ide_i),
      .rtr_i(rx_rtr_i),
      .hit_o(bank_hit[g])
    );
  end

  // Inactive banks never count, even if their words happen to match
  assign live_hit = bank_hit & state_reg.active;

  cfp_first_hit #(
    .N(NUM_BANKS),
    .IW(IW)
  ) u_first (
    .hits_i(live_hit),
    .any_o(any_hit),
    .index_o(hit_index)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic req;
    logic [11:0] ofs;
    logic [11:0] bank_ofs;
    logic [WW-1:0] widx;
    logic in_bank;
    logic [31:0] cur;
    logic [31:0] wv;
    req = 1'b0;
    ofs = 12'h000;
    bank_ofs = 12'h000;
    widx = '0;
    in_bank = 1'b0;
    cur = CFP_ZERO_RESET;
    wv = CFP_ZERO_RESET;
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.acc_valid = 1'b0;
    state_next.discard = 1'b0;

    // Register access: one answer per request, ack drops the cycle after
    req = wb_cyc_i && wb_stb_i && !state_reg.ack;
    ofs = {wb_adr_i[CFP_ADR_W-1:2], 2'b00};
    bank_ofs = ofs - CFP_BANK_FIRST_OFS;
    widx = bank_ofs[WW+1:2];
    in_bank = (ofs >= CFP_BANK_FIRST_OFS) && (ofs <= CFP_BANK_LAST_OFS);

    // Read mux; reserved bits of the master word keep their reset pattern
    if (ofs == CFP_MASTER_OFS) begin
      cur = {CFP_MASTER_RESET[31:1], state_reg.init_mode};
    end else if (ofs == CFP_MODE_OFS) begin
      cur = 32'(state_reg.list_mode);
    end else if (ofs == CFP_SCALE_OFS) begin
      cur = 32'(state_reg.scale_32);
    end else if (ofs == CFP_ROUTE_OFS) begin
      cur = 32'(state_reg.fifo_sel);
    end else if (ofs == CFP_ACT_OFS) begin
      cur = 32'(state_reg.active);
    end else if (in_bank) begin
      cur = state_reg.bank_words[widx];
    end else begin
      cur = CFP_ZERO_RESET;
    end
    wv = merge_lanes(cur, wb_dat_i, wb_sel_i);

    if (req) begin
      state_next.ack = 1'b1;
      state_next.rdata = cur;
      if (wb_we_i) begin
        // Upper bits of wv are simply dropped; software keeps them zero
        if (ofs == CFP_MASTER_OFS) begin
          state_next.init_mode = wv[CFP_INIT_BIT];
        end else if (ofs == CFP_MODE_OFS) begin
          if (state_reg.init_mode) begin
            state_next.list_mode = wv[NUM_BANKS-1:0];
          end
        end else if (ofs == CFP_SCALE_OFS) begin
          if (state_reg.init_mode) begin
            state_next.scale_32 = wv[NUM_BANKS-1:0];
          end
        end else if (ofs == CFP_ROUTE_OFS) begin
          if (state_reg.init_mode) begin
            state_next.fifo_sel = wv[NUM_BANKS-1:0];
          end
        end else if (ofs == CFP_ACT_OFS) begin
          state_next.active = wv[NUM_BANKS-1:0];
        end else if (in_bank) begin
          // A live bank would change its verdict mid-frame, so it is locked outside init mode
          if (state_reg.init_mode || !state_reg.active[widx[WW-1:1]]) begin
            state_next.bank_words[widx] = wv;
          end
        end
      end
    end

    // Filtering verdict, one cycle after the identifier is offered
    if (rx_frame_valid_i) begin
      if (!state_reg.init_mode && any_hit) begin
        state_next.acc_valid = 1'b1;
        state_next.acc_bank = hit_index;
        state_next.acc_fifo1 = state_reg.fifo_sel[hit_index];
      end else begin
        state_next.discard = 1'b1;
      end
    end

    // Bank words are not reset on purpose: they hold no defined value
    if (rst_i) begin
      state_next.init_mode = CFP_MASTER_RESET[CFP_INIT_BIT];
      state_next.list_mode = '0;
      state_next.scale_32 = '0;
      state_next.fifo_sel = '0;
      state_next.active = '0;
      state_next.ack = 1'b0;
      state_next.rdata = CFP_ZERO_RESET;
      state_next.acc_valid = 1'b0;
      state_next.acc_fifo1 = 1'b0;
      state_next.acc_bank = '0;
      state_next.discard = 1'b0;
    end
  end

  // ************************************************************
  // Registers and outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
  assign acc_valid_o = state_reg.acc_valid;
  assign acc_fifo1_o = state_reg.acc_fifo1;
  assign acc_bank_o = state_reg.acc_bank;
  assign discard_o = state_reg.discard;

endmodule : cfp_filter_config

// file: verification/cfp_filter_config_chk.sv
// Checker for the filter configuration block, bound to its top module.
// Assumes the master writes whole words (wb_sel_i all ones).
`timescale 1ns/1ps
module cfp_filter_config_chk import cfp_pkg::*; #(
  parameter int unsigned NUM_BANKS = CFP_NUM_BANKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [CFP_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Frame path
  input wire logic rx_frame_valid_i,
  input wire logic [10:0] rx_std_id_i,
  input wire logic [17:0] rx_ext_id_i,
  input wire logic rx_ide_i,
  input wire logic rx_rtr_i,
  input wire logic acc_valid_o,
  input wire logic acc_fifo1_o,
  input wire logic [$clog2(NUM_BANKS)-1:0] acc_bank_o,
  input wire logic discard_o
);
  // ************************************************************
  // Shadow of init mode and activation, updated where a write is taken
  // ************************************************************
  logic init_reg;
  logic [13:0] act_reg;
  logic [13:0] act_d_reg;
  logic take;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & (wb_sel_i == 4'hF);
  always_ff @(posedge clk_i) begin
    act_d_reg <= rst_i ? 14'h0000 : act_reg;
    if (rst_i) begin
      init_reg <= 1'b1;
      act_reg <= 14'h0000;
    end else if (take && wb_adr_i[11:2] == 10'h080) begin
      init_reg <= wb_dat_i[0];
    end else if (take && wb_adr_i[11:2] == 10'h087) begin
      act_reg <= wb_dat_i[13:0];
    end
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack_answer; s_req |=> s_ack_pulse; endproperty
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_unmapped_zero; wb_ack_o && !wb_we_i && wb_adr_i < 12'h200 |-> wb_dat_o == 32'h0000_0000; endproperty
  property p_upper_zero;
    wb_ack_o && !wb_we_i && (wb_adr_i[11:2] == 10'h085 || wb_adr_i[11:2] == 10'h087) |-> wb_dat_o[31:14] == 18'h0_0000;
  endproperty
  property p_verdict; rx_frame_valid_i |=> acc_valid_o != discard_o; endproperty
  property p_verdict_cause; acc_valid_o || discard_o |-> $past(rx_frame_valid_i); endproperty
  property p_init_discard; rx_frame_valid_i && init_reg |=> discard_o; endproperty
  property p_active_only; acc_valid_o |-> act_d_reg[acc_bank_o]; endproperty
  a_ack_answer:
    assert property (p_ack_answer) else $error("ack missing or longer than one cycle");
  a_ack_cause:
    assert property (p_ack_cause) else $error("ack without request");
  a_unmapped_zero:
    assert property (p_unmapped_zero) else $error("unmapped read not zero");
  a_upper_zero:
    assert property (p_upper_zero) else $error("upper bits of routing or activation not zero");
  a_verdict:
    assert property (p_verdict) else $error("frame without exactly one verdict");
  a_verdict_cause:
    assert property (p_verdict_cause) else $error("verdict without frame");
  a_init_discard:
    assert property (p_init_discard) else $error("frame accepted in init mode");
  a_active_only:
    assert property (p_active_only) else $error("inactive bank accepted a frame");
endmodule : cfp_filter_config_chk

bind cfp_filter_config cfp_filter_config_chk #(.NUM_BANKS(NUM_BANKS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_frame_valid_i(rx_frame_valid_i),
  .rx_std_id_i(rx_std_id_i), .rx_ext_id_i(rx_ext_id_i), .rx_ide_i(rx_ide_i), .rx_rtr_i(rx_rtr_i),
  .acc_valid_o(acc_valid_o), .acc_fifo1_o(acc_fifo1_o), .acc_bank_o(acc_bank_o), .discard_o(discard_o));

// file: verification/cfp_rx_model.sv
// Receive path model: sends one identifier per call and captures the verdict.
// Assumes the caller enters send right after a rising edge.
`timescale 1ns/1ps
module cfp_rx_model (
  // Clock
  input wire logic clk_i,
  // Identifier toward the filter
  output logic valid_o = 1'b0,
  output logic [10:0] std_o = 11'h000,
  output logic [17:0] ext_o = 18'h0_0000,
  output logic ide_o = 1'b0,
  output logic rtr_o = 1'b0,
  // Verdict from the filter
  input wire logic acc_i,
  input wire logic fifo1_i,
  input wire logic [3:0] bank_i,
  input wire logic disc_i,
  output logic got_acc_o,
  output logic got_f1_o,
  output logic [3:0] got_bank_o,
  output logic got_disc_o
);
  task automatic send(input logic [10:0] s, input logic [17:0] e);
    valid_o <= 1'b1;
    {std_o, ext_o, ide_o, rtr_o} <= {s, e, 2'b00};
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Lines no longer valid show the inverse so stale values never match
    {std_o, ext_o, ide_o, rtr_o} <= ~{s, e, 2'b00};
    #1;
    // Verdict pulses last one cycle, so capture them now
    {got_acc_o, got_f1_o, got_bank_o, got_disc_o} = {acc_i, fifo1_i, bank_i, disc_i};
  endtask : send
endmodule : cfp_rx_model

// file: verification/cfp_filter_config_tb.sv
// Testbench for the filter configuration block: register access and frame verdicts.
// Assumes the checker is bound to the design and the receive model drives identifiers.
`timescale 1ns/1ps
module cfp_filter_config_tb import cfp_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  logic [10:0] std;
  logic [17:0] ext;
  logic [3:0] bank, got_bank;
  logic wb_ack_o, vld, ide, rtr, acc, f1, disc, got_acc, got_f1, got_disc;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  cfp_filter_config u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_frame_valid_i(vld), .rx_std_id_i(std), .rx_ext_id_i(ext), .rx_ide_i(ide),
    .rx_rtr_i(rtr), .acc_valid_o(acc), .acc_fifo1_o(f1), .acc_bank_o(bank), .discard_o(disc));
  cfp_rx_model u_rx (.clk_i(clk_i), .valid_o(vld), .std_o(std), .ext_o(ext), .ide_o(ide), .rtr_o(rtr),
    .acc_i(acc), .fifo1_i(f1), .bank_i(bank), .disc_i(disc), .got_acc_o(got_acc), .got_f1_o(got_f1),
    .got_bank_o(got_bank), .got_disc_o(got_disc));
  initial forever #5 clk_i = ~clk_i;
  // Ceiling well above the hundred or so cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd
  task automatic frame(input logic [10:0] s, input logic [17:0] e, input logic ea, input logic ef, input logic [3:0] eb);
    u_rx.send(s, e);
    chk({got_acc, got_disc}, {ea, ~ea});
    if (ea) chk({got_f1, got_bank}, {ef, eb});
    @(posedge clk_i);
  endtask : frame
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // ************************************************************
    // Reset values and unmapped space
    // ************************************************************
    rd(12'h200, CFP_MASTER_RESET);
    rd(12'h204, CFP_ZERO_RESET);
    rd(12'h20C, CFP_ZERO_RESET);
    rd(12'h214, CFP_ZERO_RESET);
    rd(12'h21C, CFP_ZERO_RESET);
    rd(12'h100, CFP_ZERO_RESET);
    $display("test reset done");
    // ************************************************************
    // Bank 3 mask on std id to FIFO 1, bank 5 list, both 32-bit
    // ************************************************************
    xfer(1'b1, 12'h204, 32'h0000_0020);
    xfer(1'b1, 12'h20C, 32'h0000_0028);
    xfer(1'b1, 12'h214, 32'h0000_0008);
    xfer(1'b1, 12'h258, 32'h2460_0000);
    xfer(1'b1, 12'h25C, 32'hFFE0_0000);
    xfer(1'b1, 12'h268, 32'h0AA0_0000);
    xfer(1'b1, 12'h26C, 32'h0CC0_0000);
    xfer(1'b1, 12'h21C, 32'h0000_0028);
    frame(11'h123, 18'h3_ABCD, 1'b0, 1'b0, 4'h0);
    xfer(1'b1, 12'h200, 32'h0000_0000);
    frame(11'h123, 18'h3_ABCD, 1'b1, 1'b1, 4'h3);
    frame(11'h122, 18'h0_0000, 1'b0, 1'b0, 4'h0);
    frame(11'h066, 18'h0_0000, 1'b1, 1'b0, 4'h5);
    frame(11'h055, 18'h0_0001, 1'b0, 1'b0, 4'h0);
    $display("test filtering done");
    // ************************************************************
    // Write protection outside init mode
    // ************************************************************
    xfer(1'b1, 12'h214, 32'h0000_0000);
    rd(12'h214, 32'h0000_0008);
    xfer(1'b1, 12'h258, 32'h0000_0000);
    rd(12'h258, 32'h2460_0000);
    xfer(1'b1, 12'h240, 32'hFFE0_4000);
    xfer(1'b1, 12'h244, 32'hFFFF_FFFF);
    rd(12'h240, 32'hFFE0_4000);
    rd(12'h244, 32'hFFFF_FFFF);
    xfer(1'b1, 12'h21C, 32'h0000_0021);
    rd(12'h21C, 32'h0000_0021);
    frame(11'h200, 18'h0_0000, 1'b1, 1'b0, 4'h0);
    frame(11'h123, 18'h0_0000, 1'b0, 1'b0, 4'h0);
    xfer(1'b1, 12'h200, 32'h0000_0001);
    xfer(1'b1, 12'h214, 32'h0000_0000);
    rd(12'h214, 32'h0000_0000);
    // Init mode opens an active bank to rewrites
    xfer(1'b1, 12'h268, 32'h0BB0_0000);
    rd(12'h268, 32'h0BB0_0000);
    $display("test protection done");
    report_and_stop();
  end
endmodule : cfp_filter_config_tb
